// [rtl/dds_pkg.sv]
// shared constants and carrier types for the descriptor dma channel state
package dds_pkg;
    // =========================================================
    // register byte offsets
    localparam logic [7:0] DDS_OFF_TALLY2 = 8'h00;
    localparam logic [7:0] DDS_OFF_TALLY3 = 8'h04;
    localparam logic [7:0] DDS_OFF_TXW0 = 8'h08;
    localparam logic [7:0] DDS_OFF_TXW1 = 8'h0C;
    localparam logic [7:0] DDS_OFF_TXW2 = 8'h10;
    localparam logic [7:0] DDS_OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] DDS_OFF_IRQ_CLR = 8'h18;
    localparam logic [7:0] DDS_OFF_IRQ_EN = 8'h1C;

    // =========================================================
    // field positions and widths
    localparam int DDS_TALLY_W = 16;
    localparam int DDS_PTR_W = 30;
    localparam int DDS_PTR_LSB = 2;
    localparam int DDS_INPKT_BIT = 0;
    localparam int DDS_TRUNC_BIT = 1;
    localparam int DDS_IRQ_W = 4;
    localparam int DDS_IRQ_START = 0;
    localparam int DDS_IRQ_END = 1;
    localparam int DDS_IRQ_TRUNC = 2;
    localparam int DDS_IRQ_TALLY0 = 3;

    // =========================================================
    // reset values
    localparam logic [15:0] DDS_TALLY_RST = 16'h0000;
    localparam logic [29:0] DDS_PTR_RST = 30'h00000000;
    localparam logic [3:0] DDS_IRQ_RST = 4'h0;

    // =========================================================
    // ahb-lite encodings
    localparam logic [1:0] DDS_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] DDS_HTRANS_SEQ = 2'h3;

    // =========================================================
    // carrier types
    typedef struct packed {
        logic loadHead;            // new queue front pointer
        logic [29:0] headPtr;
        logic startPkt;            // packet begins, sop pointer loaded
        logic [29:0] sopPtr;
        logic nextDesc;            // a new buffer supplies data
        logic [29:0] curPtr;
        logic truncNonEop;         // cut short inside non-final buffer
        logic endPkt;              // packet finished
    } dds_tx_evt_t;

    typedef struct packed {
        logic consume2;            // one buffer taken from channel 2
        logic consume3;            // one buffer taken from channel 3
    } dds_rx_evt_t;
endpackage

// [rtl/dds_channel_state.sv]
// register block holding receive tallies and transmit dma state words
// Functional notes
// - channel 2 keeps a software readable 16-bit buffer tally in bits 15-0.
// - a software write to a tally adds the value to the present count.
// - channel 3 keeps its own 16-bit tally with the same add-on-write.
// - word 0 bits 31-2 hold the 30-bit queue front descriptor pointer.
// - bit 0 of words 0 and 1 reads 1 while inside a packet, else 0.
// - word 1 bits 31-2 hold the pointer to the packet's first descriptor.
// - word 2 bits 31-2 hold the pointer to the active descriptor.
// - word 2 bit 1 is 1 when the packet was cut inside a non-final buffer.
//
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module dds_channel_state
    import dds_pkg::*;
(
    input wire logic core_clk,             // 40 MHz clock
    input wire logic reset_n,              // synchronous reset, low
    input wire logic hsel,                 // slave select
    input wire logic [31:0] haddr,         // byte address
    input wire logic [1:0] htrans,         // transfer type
    input wire logic hwrite,               // write when high
    input wire logic [2:0] hsize,          // transfer size
    input wire logic [31:0] hwdata,        // write data
    input wire logic hready,               // bus ready
    output logic hreadyout,                // slave ready
    output logic [31:0] hrdata,            // read data
    output logic hresp,                    // always okay
    input wire dds_tx_evt_t txEvt,         // transmit engine events
    input wire dds_rx_evt_t rxEvt,         // receive engine events
    output logic [31:0] headAddr,          // queue front byte address
    output logic [31:0] sopAddr,           // first descriptor byte address
    output logic [31:0] curAddr,           // active descriptor byte address
    output logic inPacket,                 // mid-packet flag
    output logic [15:0] tally2,            // channel 2 tally
    output logic [15:0] tally3,            // channel 3 tally
    output logic irq                       // level interrupt
);

    // =========================================================
    // helpers

    // add-on-write plus one decrement per consumed buffer while the sum is nonzero; holds at zero
    function automatic logic [15:0] tallyNext(
        input logic [15:0] cur,
        input logic wr,
        input logic [15:0] add,
        input logic dec
    );
        logic [15:0] sum;
        sum = wr ? 16'(cur + add) : cur;
        if (dec && (sum != 16'h0000)) begin
            sum = 16'(sum - 16'h0001);
        end
        return sum;
    endfunction

    // a stored pointer widened to a byte address
    function automatic logic [31:0] byteAddr(input logic [29:0] ptr);
        return {ptr, 2'b00};
    endfunction

    // =========================================================
    // state
    logic [15:0] tally2_q;
    logic [15:0] tally3_q;
    logic [29:0] headPtr_q;
    logic [29:0] sopPtr_q;
    logic [29:0] curPtr_q;
    logic inPacket_q;
    logic trunc_q;
    logic [3:0] irqStat_q;
    logic [3:0] irqEn_q;
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic [31:0] rdata_q;

    // =========================================================
    // bus address phase

    logic addrValid;
    logic wrStrobe;
    logic [15:0] wdLow;
    logic [3:0] evt;

    // only nonseq or seq with the bus ready start a transfer
    assign addrValid = hsel && hready &&
        ((htrans == DDS_HTRANS_NONSEQ) || (htrans == DDS_HTRANS_SEQ));
    // the write lands in the data phase, when hwdata stands
    assign wrStrobe = wrPend_q;
    assign wdLow = hwdata[15:0];

    // capture a write for its data phase
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end else begin
            wrPend_q <= addrValid && hwrite;
            if (addrValid) begin
                wrAddr_q <= haddr[7:0];
            end
        end
    end

    // =========================================================
    // write decode, one strobe per writable register

    logic wrTally2;
    logic wrTally3;
    logic wrWord0;
    logic wrWord1;
    logic wrWord2;
    logic wrIrqClr;
    logic wrIrqEn;

    // each strobe is live only in the data phase of a taken write
    assign wrTally2 = wrStrobe && (wrAddr_q == DDS_OFF_TALLY2);
    assign wrTally3 = wrStrobe && (wrAddr_q == DDS_OFF_TALLY3);
    assign wrWord0 = wrStrobe && (wrAddr_q == DDS_OFF_TXW0);
    assign wrWord1 = wrStrobe && (wrAddr_q == DDS_OFF_TXW1);
    assign wrWord2 = wrStrobe && (wrAddr_q == DDS_OFF_TXW2);
    assign wrIrqClr = wrStrobe && (wrAddr_q == DDS_OFF_IRQ_CLR);
    assign wrIrqEn = wrStrobe && (wrAddr_q == DDS_OFF_IRQ_EN);

    // =========================================================
    // next values
    //
    // every register is computed here as a next value and the flops
    // below only copy it. the read path samples the next values, not
    // the flops: a read whose address phase falls in the data phase
    // of a write to the same register would otherwise return the old
    // contents, since back to back transfers carry no wait state.
    // the cost is a longer path from hwdata to the read data flop.

    logic [15:0] tally2_d;
    logic [15:0] tally3_d;
    logic [29:0] headPtr_d;
    logic [29:0] sopPtr_d;
    logic [29:0] curPtr_d;
    logic inPacket_d;
    logic trunc_d;
    logic [3:0] irqStat_d;
    logic [3:0] irqEn_d;

    // receive tallies, each channel independent of the other
    always_comb begin
        tally2_d = tallyNext(tally2_q, wrTally2, wdLow,
            rxEvt.consume2);
        tally3_d = tallyNext(tally3_q, wrTally3, wdLow,
            rxEvt.consume3);
    end

    // =========================================================
    // transmit state words
    //
    // the engine owns these words while it runs; software writes
    // exist for setup and recovery, so an engine event in the same
    // cycle as a write to the same field always wins.

    // queue front pointer
    always_comb begin
        headPtr_d = headPtr_q;
        if (txEvt.loadHead) begin
            headPtr_d = txEvt.headPtr;
        end else if (wrWord0) begin
            headPtr_d = hwdata[31:DDS_PTR_LSB];
        end
    end

    // first descriptor of the packet in flight
    always_comb begin
        sopPtr_d = sopPtr_q;
        if (txEvt.startPkt) begin
            sopPtr_d = txEvt.sopPtr;
        end else if (wrWord1) begin
            sopPtr_d = hwdata[31:DDS_PTR_LSB];
        end
    end

    // descriptor whose buffer is being drained; sop is also current
    always_comb begin
        curPtr_d = curPtr_q;
        if (txEvt.nextDesc) begin
            curPtr_d = txEvt.curPtr;
        end else if (txEvt.startPkt) begin
            curPtr_d = txEvt.sopPtr;
        end else if (wrWord2) begin
            curPtr_d = hwdata[31:DDS_PTR_LSB];
        end
    end

    // one flag seen through words 0 and 1, so they never disagree
    always_comb begin
        inPacket_d = inPacket_q;
        if (txEvt.startPkt) begin
            inPacket_d = 1'b1;
        end else if (txEvt.endPkt) begin
            inPacket_d = 1'b0;
        end else if (wrWord0 || wrWord1) begin
            inPacket_d = hwdata[DDS_INPKT_BIT];
        end
    end

    // truncation flag; cleared at the next packet start, set wins
    always_comb begin
        trunc_d = trunc_q;
        if (txEvt.truncNonEop) begin
            trunc_d = 1'b1;
        end else if (txEvt.startPkt) begin
            trunc_d = 1'b0;
        end else if (wrWord2) begin
            trunc_d = hwdata[DDS_TRUNC_BIT];
        end
    end

    // =========================================================
    // interrupts

    // event vector in status layout
    always_comb begin
        evt = 4'h0;
        evt[DDS_IRQ_START] = txEvt.startPkt;
        evt[DDS_IRQ_END] = txEvt.endPkt;
        evt[DDS_IRQ_TRUNC] = txEvt.truncNonEop;
        evt[DDS_IRQ_TALLY0] = (rxEvt.consume2 && (tally2_q == 16'h0001)) ||
                              (rxEvt.consume3 && (tally3_q == 16'h0001));
    end

    // sticky status; a new event beats a clear in the same cycle
    always_comb begin
        irqStat_d = irqStat_q | evt;
        if (wrIrqClr) begin
            irqStat_d = (irqStat_q & ~hwdata[3:0]) | evt;
        end
    end

    // enable mask, plain read/write
    always_comb begin
        irqEn_d = irqEn_q;
        if (wrIrqEn) begin
            irqEn_d = hwdata[3:0];
        end
    end

    // =========================================================
    // state flops, one process for each concern

    // receive tallies
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tally2_q <= DDS_TALLY_RST;
            tally3_q <= DDS_TALLY_RST;
        end else begin
            tally2_q <= tally2_d;
            tally3_q <= tally3_d;
        end
    end

    // transmit pointers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            headPtr_q <= DDS_PTR_RST;
            sopPtr_q <= DDS_PTR_RST;
            curPtr_q <= DDS_PTR_RST;
        end else begin
            headPtr_q <= headPtr_d;
            sopPtr_q <= sopPtr_d;
            curPtr_q <= curPtr_d;
        end
    end

    // transmit flags
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            inPacket_q <= 1'b0;
            trunc_q <= 1'b0;
        end else begin
            inPacket_q <= inPacket_d;
            trunc_q <= trunc_d;
        end
    end

    // interrupt status and enable
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irqStat_q <= DDS_IRQ_RST;
            irqEn_q <= DDS_IRQ_RST;
        end else begin
            irqStat_q <= irqStat_d;
            irqEn_q <= irqEn_d;
        end
    end

    // =========================================================
    // read path

    // read data registered at the address phase from the next values,
    // so it matches what the registers hold once the edge has passed;
    // unmapped places and the clear register read zero
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata_q <= 32'h00000000;
        end else if (addrValid && !hwrite) begin
            case (haddr[7:0])
                DDS_OFF_TALLY2: rdata_q <= {16'h0000, tally2_d};
                DDS_OFF_TALLY3: rdata_q <= {16'h0000, tally3_d};
                DDS_OFF_TXW0: rdata_q <= {headPtr_d, 1'b0, inPacket_d};
                DDS_OFF_TXW1: rdata_q <= {sopPtr_d, 1'b0, inPacket_d};
                DDS_OFF_TXW2: rdata_q <= {curPtr_d, trunc_d, 1'b0};
                DDS_OFF_IRQ_STAT: rdata_q <= {28'h0000000, irqStat_d};
                DDS_OFF_IRQ_EN: rdata_q <= {28'h0000000, irqEn_d};
                default: rdata_q <= 32'h00000000;
            endcase
        end
    end

    // =========================================================
    // outputs, all from flops; zero-wait slave
    // irq follows the status and enable flops exactly, no extra lag
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            irq <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            irq <= |(irqStat_d & irqEn_d);
        end
    end

    assign hrdata = rdata_q;
    assign headAddr = byteAddr(headPtr_q);
    assign sopAddr = byteAddr(sopPtr_q);
    assign curAddr = byteAddr(curPtr_q);
    assign inPacket = inPacket_q;
    assign tally2 = tally2_q;
    assign tally3 = tally3_q;

    // hsize is unused: only whole-word transfers are supported
endmodule

// [verification/dds_channel_state_assertions.sv]
// checker watching the channel state block at its ports
`timescale 1ns/1ps
module dds_channel_state_assertions
    import dds_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic reset_n, // reset, low
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer
    input wire logic hwrite, // write
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // ready
    input wire logic [31:0] hrdata, // read data
    input wire dds_tx_evt_t txEvt, // tx events
    input wire dds_rx_evt_t rxEvt, // rx events
    input wire logic [31:0] headAddr, // front
    input wire logic [31:0] sopAddr, // first
    input wire logic [31:0] curAddr, // active
    input wire logic inPacket, // in packet
    input wire logic [15:0] tally2, // tally 2
    input wire logic [15:0] tally3 // tally 3
);
    // ====================
    // bus phase tracking
    logic wrTaken_q;
    logic rdTaken_q;
    logic [7:0] addr_q;
    // data phase trails the taken address by one edge
    always_ff @(posedge core_clk) begin
        addr_q <= haddr[7:0];
        if (!reset_n) begin
            wrTaken_q <= 1'b0;
            rdTaken_q <= 1'b0;
        end else begin
            wrTaken_q <= hsel && hready && htrans[1] && hwrite;
            rdTaken_q <= hsel && hready && htrans[1] && !hwrite;
        end
    end
    // ====================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_head_load: assert property (txEvt.loadHead |=>
        headAddr == {$past(txEvt.headPtr), 2'b00})
        else $error("front address wrong");
    a_sop_load: assert property (txEvt.startPkt |=>
        sopAddr == {$past(txEvt.sopPtr), 2'b00})
        else $error("first address wrong");
    a_cur_load: assert property (txEvt.nextDesc |=>
        curAddr == {$past(txEvt.curPtr), 2'b00})
        else $error("active address wrong");
    a_pkt_start: assert property (txEvt.startPkt |=> inPacket)
        else $error("packet flag not set");
    a_pkt_end: assert property (txEvt.endPkt && !txEvt.startPkt
        |=> !inPacket) else $error("packet flag not cleared");
    // writes accumulate; a same-edge consume is left out
    a_tally2_add: assert property (wrTaken_q && !rxEvt.consume2 &&
        addr_q == DDS_OFF_TALLY2 |=>
        tally2 == $past(tally2) + $past(hwdata[15:0]))
        else $error("tally 2 did not add");
    a_tally3_add: assert property (wrTaken_q && !rxEvt.consume3 &&
        addr_q == DDS_OFF_TALLY3 |=>
        tally3 == $past(tally3) + $past(hwdata[15:0]))
        else $error("tally 3 did not add");
    a_tally_upper: assert property (rdTaken_q && addr_q[7:3] == 5'h00
        |-> hrdata[31:16] == 16'h0000) else $error("tally upper bits");
endmodule

bind dds_channel_state dds_channel_state_assertions
    i_dds_channel_state_assertions (
    .core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hrdata, .txEvt, .rxEvt, .headAddr, .sopAddr, .curAddr,
    .inPacket, .tally2, .tally3
);

// [verification/dds_engine_model.sv]
// behavioural dma engine driving event pulses into the block
`timescale 1ns/1ps
module dds_engine_model
    import dds_pkg::*;
(
    output dds_tx_evt_t txEvt, // transmit events
    output dds_rx_evt_t rxEvt, // receive events
    input wire logic core_clk // clock
);
    // quiet at time zero
    initial begin
        txEvt = '0;
        rxEvt = '0;
    end
    // one-cycle pulse after gap edges; idle pointers turn inverse
    // so a block sampling them outside a pulse is caught
    task automatic send(input dds_tx_evt_t t, input dds_rx_evt_t r,
                        input int gap);
        dds_tx_evt_t z;
        z = ~t;
        {z.loadHead, z.startPkt, z.nextDesc, z.truncNonEop, z.endPkt} = 5'h00;
        repeat (gap) @(posedge core_clk);
        txEvt <= t;
        rxEvt <= r;
        @(posedge core_clk);
        txEvt <= z;
        rxEvt <= '0;
    endtask
endmodule

// [verification/dds_channel_state_test.sv]
// self-checking bench for the channel state block
`timescale 1ns/1ps
module dds_channel_state_test;
    import dds_pkg::*;
    // ====================
    // design and drivers
    localparam logic [29:0] HEAD = 30'h2AAAAAAA;
    localparam logic [29:0] SOP = 30'h15555555;
    localparam logic [29:0] CUR = 30'h0ABCDEF1;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h00000000;
    logic [31:0] hwdata = 32'h00000000;
    logic hreadyout, hresp, inPacket, irq;
    logic [31:0] hrdata, headAddr, sopAddr, curAddr, rd;
    logic [15:0] tally2, tally3;
    dds_tx_evt_t txEvt;
    dds_rx_evt_t rxEvt;
    int compares = 0;
    int miscompares = 0;
    always #12.5 core_clk = ~core_clk;
    dds_channel_state i_dds_channel_state (
        .core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
        .hrdata, .hresp, .txEvt, .rxEvt, .headAddr, .sopAddr,
        .curAddr, .inPacket, .tally2, .tally3, .irq
    );
    dds_engine_model i_dds_engine_model (.core_clk, .txEvt, .rxEvt);
    // ====================
    // tasks
    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // bounded wait; the slave holds hreadyout high, so each wait takes one edge
    task automatic waitRdy(inout int n);
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
    endtask
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= DDS_HTRANS_NONSEQ;
        hsel <= 1'b1;
        waitRdy(n);
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy(n);
        rd = hrdata;
        if (n >= 64) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h00000000);
        chk(rd, exp);
    endtask
    task automatic ev(input dds_tx_evt_t t, input dds_rx_evt_t r);
        i_dds_engine_model.send(t, r, 1);
    endtask
    // ====================
    // main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        // every register, clear and an unmapped place read zero
        for (int a = 0; a <= 32; a += 4)
            rdChk(8'(a), 32'h00000000);
        // writes add, wrapping at 16 bits
        bus(DDS_OFF_TALLY2, 1'b1, 32'h00000005);
        bus(DDS_OFF_TALLY2, 1'b1, 32'h0000FFFE);
        rdChk(DDS_OFF_TALLY2, 32'h00000003);
        bus(DDS_OFF_TALLY3, 1'b1, 32'h00000007);
        bus(DDS_OFF_TALLY3, 1'b1, 32'h00000002);
        rdChk(DDS_OFF_TALLY3, 32'h00000009);
        chk({16'h0000, tally3}, 32'h00000009);
        chk({31'h0, hresp}, 32'h00000000);
        ev('0, '{consume2: 1'b1, consume3: 1'b0});
        rdChk(DDS_OFF_TALLY2, 32'h00000002);
        chk({16'h0000, tally2}, 32'h00000002);
        // pointer words and the packet flags
        ev('{loadHead: 1'b1, headPtr: HEAD, default: '0}, '0);
        rdChk(DDS_OFF_TXW0, {HEAD, 2'b00});
        chk(headAddr, {HEAD, 2'b00});
        ev('{startPkt: 1'b1, sopPtr: SOP, nextDesc: 1'b1, curPtr: CUR,
             default: '0}, '0);
        rdChk(DDS_OFF_TXW1, {SOP, 2'b01});
        rdChk(DDS_OFF_TXW0, {HEAD, 2'b01});
        rdChk(DDS_OFF_TXW2, {CUR, 2'b00});
        chk(sopAddr, {SOP, 2'b00});
        chk(curAddr, {CUR, 2'b00});
        chk({31'h0, inPacket}, 32'h00000001);
        ev('{truncNonEop: 1'b1, default: '0}, '0);
        rdChk(DDS_OFF_TXW2, {CUR, 2'b10});
        // events wait in status while masked, then raise the line
        rdChk(DDS_OFF_IRQ_STAT, 32'h00000005);
        chk({31'h0, irq}, 32'h00000000);
        bus(DDS_OFF_IRQ_EN, 1'b1, 32'h0000000F);
        rdChk(DDS_OFF_IRQ_EN, 32'h0000000F);
        chk({31'h0, irq}, 32'h00000001);
        bus(DDS_OFF_IRQ_CLR, 1'b1, 32'h00000005);
        rdChk(DDS_OFF_IRQ_STAT, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        ev('{endPkt: 1'b1, default: '0}, '0);
        rdChk(DDS_OFF_TXW1, {SOP, 2'b00});
        chk({31'h0, inPacket}, 32'h00000000);
        chk({31'h0, irq}, 32'h00000001);
        bus(DDS_OFF_IRQ_EN, 1'b1, 32'h00000000);
        rdChk(DDS_OFF_IRQ_STAT, 32'h00000002);
        chk({31'h0, irq}, 32'h00000000);
        // bit 1 of word 0 is reserved and stays zero
        bus(DDS_OFF_TXW0, 1'b1, 32'h1234567B);
        rdChk(DDS_OFF_TXW0, 32'h12345679);
        close_out();
    end
endmodule
